// File: include/pfs_pkg.sv
// shared constants for the pad function select and pad control block
package pfs_pkg;

   // bus geometry
   localparam int ADDR_W   = 16;
   localparam int DATA_W   = 32;
   localparam int STRB_W   = 4;

   // byte offsets of the registers
   localparam logic [15:0] OFF_SEL_G6   = 16'h0030;
   localparam logic [15:0] OFF_SEL_G7   = 16'h0034;
   localparam logic [15:0] OFF_SEL_G8   = 16'h0038;
   localparam logic [15:0] OFF_SCAN_IN  = 16'h004C;
   localparam logic [15:0] OFF_SCAN_OUT = 16'h0050;
   localparam logic [15:0] OFF_CTL_LOW  = 16'hF008;
   localparam logic [15:0] OFF_CTL_MID  = 16'hF00C;
   localparam logic [15:0] OFF_WAKE_LVL = 16'hF040;

   // storage indices; the level register has no storage
   localparam int NUM_RW = 7;
   localparam logic [2:0] IDX_SEL_G6   = 3'h0;
   localparam logic [2:0] IDX_SEL_G7   = 3'h1;
   localparam logic [2:0] IDX_SEL_G8   = 3'h2;
   localparam logic [2:0] IDX_SCAN_IN  = 3'h3;
   localparam logic [2:0] IDX_SCAN_OUT = 3'h4;
   localparam logic [2:0] IDX_CTL_LOW  = 3'h5;
   localparam logic [2:0] IDX_CTL_MID  = 3'h6;
   localparam logic [2:0] IDX_WAKE_LVL = 3'h7;

   // function select field layout
   localparam int FSEL_W      = 6;
   localparam int FSEL_STRIDE = 8;
   localparam int FSEL_PER    = 4;
   localparam int FSEL_PADS   = 11;

   // pad control slot layout
   localparam int SLOT_W      = 3;
   localparam int SLOT_WAKE   = 0;
   localparam int SLOT_PULL   = 1;
   localparam int PULL_W      = 2;
   localparam int PINS_PER    = 10;
   localparam int CTL_PINS    = 20;
   localparam int TEST_SLOT   = 8;
   localparam int TEST_LSB    = 24;
   localparam int TEST_W      = 3;
   localparam int PIN03_PULL_LSB = 10;

   // pull encodings
   localparam logic [1:0] PULL_NONE   = 2'h0;
   localparam logic [1:0] PULL_WEAK   = 2'h1;
   localparam logic [1:0] PULL_STRONG = 2'h2;
   localparam logic [1:0] PULL_DOWN   = 2'h3;

   // reset values
   localparam logic [2:0] TEST_CFG_RST  = 3'h6;
   localparam logic [1:0] PIN03_PULL_RST = PULL_DOWN;
   localparam logic [31:0] RST_CTL_LOW = (32'(TEST_CFG_RST) << TEST_LSB)
                                       | (32'(PIN03_PULL_RST) << PIN03_PULL_LSB);
   localparam logic [31:0] RST_ZERO    = 32'h0000_0000;

   // writable bits of each register; the rest read as zero
   localparam logic [31:0] MASK_SEL_FULL = 32'h3F3F_3F3F;
   localparam logic [31:0] MASK_SEL_G8   = 32'h003F_3F3F;
   localparam logic [31:0] MASK_SCAN_IN  = 32'h0000_FFFF;
   localparam logic [31:0] MASK_SCAN_OUT = 32'h0003_FFFF;
   localparam logic [31:0] MASK_CTL      = 32'h3FFF_FFFF;

   localparam logic [NUM_RW-1:0][31:0] REG_MASK = {MASK_CTL, MASK_CTL, MASK_SCAN_OUT,
      MASK_SCAN_IN, MASK_SEL_G8, MASK_SEL_FULL, MASK_SEL_FULL};
   localparam logic [NUM_RW-1:0][31:0] REG_RST = {RST_ZERO, RST_CTL_LOW, RST_ZERO,
      RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // wake pin settling after reset
   localparam logic [1:0] WARM_DONE = 2'h3;

endpackage : pfs_pkg

// File: core/pfs_axil_slave.sv
// axi4-lite slave front end for the pad control register file
`timescale 1ns/100ps
module pfs_axil_slave
   import pfs_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] awaddr_i,
   input  wire logic              awvalid_i,
   output logic                   awready_o,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic [STRB_W-1:0] wstrb_i,
   input  wire logic              wvalid_i,
   output logic                   wready_o,
   output logic [1:0]             bresp_o,
   output logic                   bvalid_o,
   input  wire logic              bready_i,
   input  wire logic [ADDR_W-1:0] araddr_i,
   input  wire logic              arvalid_i,
   output logic                   arready_o,
   output logic [DATA_W-1:0]      rdata_o,
   output logic [1:0]             rresp_o,
   output logic                   rvalid_o,
   input  wire logic              rready_i,
   output logic                   wr_en_o,
   output logic [ADDR_W-1:0]      wr_addr_o,
   output logic [DATA_W-1:0]      wr_data_o,
   output logic [STRB_W-1:0]      wr_strb_o,
   input  wire logic              wr_hit_i,
   output logic                   rd_en_o,
   output logic [ADDR_W-1:0]      rd_addr_o,
   input  wire logic [DATA_W-1:0] rd_data_i,
   input  wire logic              rd_hit_i
);

   logic              aw_held_r, aw_held_nxt;
   logic              w_held_r,  w_held_nxt;
   logic [ADDR_W-1:0] awaddr_r,  awaddr_nxt;
   logic [DATA_W-1:0] wdata_r,   wdata_nxt;
   logic [STRB_W-1:0] wstrb_r,   wstrb_nxt;
   logic              awready_r, awready_nxt;
   logic              wready_r,  wready_nxt;
   logic              bvalid_r,  bvalid_nxt;
   logic [1:0]        bresp_r,   bresp_nxt;
   logic              arready_r, arready_nxt;
   logic              rvalid_r,  rvalid_nxt;
   logic [1:0]        rresp_r,   rresp_nxt;
   logic [DATA_W-1:0] rdata_r,   rdata_nxt;

   // address and data are caught separately; commit waits for both
   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt  = w_held_r;
      awaddr_nxt  = awaddr_r;
      wdata_nxt   = wdata_r;
      wstrb_nxt   = wstrb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r;
      rresp_nxt   = rresp_r;
      rdata_nxt   = rdata_r;
      wr_en_o     = 1'b0;
      rd_en_o     = 1'b0;
      if (awvalid_i && awready_r) begin
         aw_held_nxt = 1'b1;
         awaddr_nxt  = awaddr_i;
      end
      if (wvalid_i && wready_r) begin
         w_held_nxt = 1'b1;
         wdata_nxt  = wdata_i;
         wstrb_nxt  = wstrb_i;
      end
      if (bvalid_r && bready_i) begin
         bvalid_nxt = 1'b0;
      end
      // an unmapped write still answers, with slverr
      if (aw_held_r && w_held_r && !bvalid_r) begin
         wr_en_o     = 1'b1;
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = wr_hit_i ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_r && rready_i) begin
         rvalid_nxt = 1'b0;
      end
      if (arvalid_i && arready_r) begin
         rd_en_o    = 1'b1;
         rvalid_nxt = 1'b1;
         rdata_nxt  = rd_hit_i ? rd_data_i : '0;
         rresp_nxt  = rd_hit_i ? RESP_OKAY : RESP_SLVERR;
      end
      awready_nxt = !aw_held_nxt;
      wready_nxt  = !w_held_nxt;
      arready_nxt = !rvalid_nxt;  // one read in flight at a time
      if (rst_i) begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b0;
         rvalid_nxt  = 1'b0;
         awready_nxt = 1'b0;
         wready_nxt  = 1'b0;
         arready_nxt = 1'b0;
         bresp_nxt   = RESP_OKAY;
         rresp_nxt   = RESP_OKAY;
         rdata_nxt   = '0;
      end
   end

   // channel state registers
   always_ff @(posedge clock_i) begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
   end

   // every axi output is a flop; rd_addr_o is araddr_i passed straight through
   assign awready_o = awready_r;
   assign wready_o  = wready_r;
   assign bvalid_o  = bvalid_r;
   assign bresp_o   = bresp_r;
   assign arready_o = arready_r;
   assign rvalid_o  = rvalid_r;
   assign rresp_o   = rresp_r;
   assign rdata_o   = rdata_r;
   assign wr_addr_o = awaddr_r;
   assign wr_data_o = wdata_r;
   assign wr_strb_o = wstrb_r;
   assign rd_addr_o = araddr_i;

endmodule : pfs_axil_slave

// File: core/pfs_pad_ctrl.sv
// pad function select, pull and wake polarity control with axi4-lite registers
`timescale 1ns/100ps
module pfs_pad_ctrl
   import pfs_pkg::*;
(
   input  wire logic                        clock_i,
   input  wire logic                        rst_i,
   input  wire logic [ADDR_W-1:0]           s_axi_awaddr_i,
   input  wire logic                        s_axi_awvalid_i,
   output logic                             s_axi_awready_o,
   input  wire logic [DATA_W-1:0]           s_axi_wdata_i,
   input  wire logic [STRB_W-1:0]           s_axi_wstrb_i,
   input  wire logic                        s_axi_wvalid_i,
   output logic                             s_axi_wready_o,
   output logic [1:0]                       s_axi_bresp_o,
   output logic                             s_axi_bvalid_o,
   input  wire logic                        s_axi_bready_i,
   input  wire logic [ADDR_W-1:0]           s_axi_araddr_i,
   input  wire logic                        s_axi_arvalid_i,
   output logic                             s_axi_arready_o,
   output logic [DATA_W-1:0]                s_axi_rdata_o,
   output logic [1:0]                       s_axi_rresp_o,
   output logic                             s_axi_rvalid_o,
   input  wire logic                        s_axi_rready_i,
   output logic [FSEL_PADS*FSEL_W-1:0]      pad_func_sel_o,
   output logic [15:0]                      scan_in_en_o,
   output logic [17:0]                      scan_out_en_o,
   output logic [CTL_PINS-1:0]              pull_weak_up_o,
   output logic [CTL_PINS-1:0]              pull_strong_up_o,
   output logic [CTL_PINS-1:0]              pull_down_o,
   output logic [CTL_PINS-1:0]              wake_negedge_o,
   output logic [TEST_W-1:0]                test_config_pin_o,
   input  wire logic [CTL_PINS-1:0]         wake_pin_i,
   output logic [CTL_PINS-1:0]              wake_event_o
);

   logic [NUM_RW-1:0][31:0]    reg_r;
   logic [NUM_RW-1:0][31:0]    reg_nxt;
   logic                       wr_en;
   logic [ADDR_W-1:0]          wr_addr;
   logic [DATA_W-1:0]          wr_data;
   logic [STRB_W-1:0]          wr_strb;
   logic                       wr_hit;
   logic [2:0]                 wr_idx;
   logic                       rd_en;
   logic [ADDR_W-1:0]          rd_addr;
   logic [DATA_W-1:0]          rd_data;
   logic                       rd_hit;
   logic [2:0]                 rd_idx;
   logic [31:0]                byte_mask;

   logic [FSEL_PADS*FSEL_W-1:0] sel_r,    sel_nxt;
   logic [15:0]                 sin_r;
   logic [17:0]                 sout_r;
   logic [CTL_PINS-1:0]         weak_r,   weak_nxt;
   logic [CTL_PINS-1:0]         strong_r, strong_nxt;
   logic [CTL_PINS-1:0]         down_r,   down_nxt;
   logic [CTL_PINS-1:0]         neg_r,    neg_nxt;
   logic [TEST_W-1:0]           test_r;

   logic [CTL_PINS-1:0]         wake_meta_r;
   logic [CTL_PINS-1:0]         wake_sync_r;
   logic [CTL_PINS-1:0]         wake_prev_r;
   logic [CTL_PINS-1:0]         wake_ev_r,  wake_ev_nxt;
   logic [1:0]                  warm_r,     warm_nxt;

   // address decode shared by both directions; bit 3 is the hit flag
   function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
      logic [3:0] d;
      d = 4'h0;
      case (a)
         OFF_SEL_G6:   d = {1'b1, IDX_SEL_G6};
         OFF_SEL_G7:   d = {1'b1, IDX_SEL_G7};
         OFF_SEL_G8:   d = {1'b1, IDX_SEL_G8};
         OFF_SCAN_IN:  d = {1'b1, IDX_SCAN_IN};
         OFF_SCAN_OUT: d = {1'b1, IDX_SCAN_OUT};
         OFF_CTL_LOW:  d = {1'b1, IDX_CTL_LOW};
         OFF_CTL_MID:  d = {1'b1, IDX_CTL_MID};
         OFF_WAKE_LVL: d = {1'b1, IDX_WAKE_LVL};
         default:      d = 4'h0;
      endcase
      return d;
   endfunction : decode

   pfs_axil_slave u_bus (
      .clock_i   (clock_i),
      .rst_i     (rst_i),
      .awaddr_i  (s_axi_awaddr_i),
      .awvalid_i (s_axi_awvalid_i),
      .awready_o (s_axi_awready_o),
      .wdata_i   (s_axi_wdata_i),
      .wstrb_i   (s_axi_wstrb_i),
      .wvalid_i  (s_axi_wvalid_i),
      .wready_o  (s_axi_wready_o),
      .bresp_o   (s_axi_bresp_o),
      .bvalid_o  (s_axi_bvalid_o),
      .bready_i  (s_axi_bready_i),
      .araddr_i  (s_axi_araddr_i),
      .arvalid_i (s_axi_arvalid_i),
      .arready_o (s_axi_arready_o),
      .rdata_o   (s_axi_rdata_o),
      .rresp_o   (s_axi_rresp_o),
      .rvalid_o  (s_axi_rvalid_o),
      .rready_i  (s_axi_rready_i),
      .wr_en_o   (wr_en),
      .wr_addr_o (wr_addr),
      .wr_data_o (wr_data),
      .wr_strb_o (wr_strb),
      .wr_hit_i  (wr_hit),
      .rd_en_o   (rd_en),
      .rd_addr_o (rd_addr),
      .rd_data_i (rd_data),
      .rd_hit_i  (rd_hit)
   );

   // byte lanes widened to a bit mask
   always_comb begin
      for (int b = 0; b < STRB_W; b++) begin
         byte_mask[b*8 +: 8] = {8{wr_strb[b]}};
      end
   end

   // register file next state; the level word ignores writes
   always_comb begin
      {wr_hit, wr_idx} = decode(wr_addr);
      reg_nxt = reg_r;
      if (wr_en && wr_hit && (wr_idx != IDX_WAKE_LVL)) begin
         reg_nxt[wr_idx] = ((reg_r[wr_idx] & ~byte_mask) | (wr_data & byte_mask))
                         & REG_MASK[wr_idx];
      end
      if (rst_i) begin
         reg_nxt = REG_RST;
      end
   end

   // read mux; storage is always masked so reserved bits come back zero
   always_comb begin
      {rd_hit, rd_idx} = decode(rd_addr);
      rd_data = '0;
      if (rd_en && rd_hit) begin
         if (rd_idx == IDX_WAKE_LVL) begin
            rd_data = {{(DATA_W-CTL_PINS){1'b0}}, wake_sync_r};
         end else begin
            rd_data = reg_r[rd_idx] & REG_MASK[rd_idx];
         end
      end
   end

   // function select fields for pads 24 to 34
   for (genvar k = 0; k < FSEL_PADS; k++) begin : g_fsel
      localparam int RI  = int'(IDX_SEL_G6) + k / FSEL_PER;
      localparam int LSB = (k % FSEL_PER) * FSEL_STRIDE;
      assign sel_nxt[k*FSEL_W +: FSEL_W] = reg_nxt[RI][LSB +: FSEL_W];
   end

   // per-pin pull decode and wake polarity
   for (genvar p = 0; p < CTL_PINS; p++) begin : g_pin
      localparam int RI = (p < PINS_PER) ? int'(IDX_CTL_LOW) : int'(IDX_CTL_MID);
      localparam int SB = (p % PINS_PER) * SLOT_W;
      if (p == TEST_SLOT) begin : g_test
         // slot taken by the test config field: no pull, no wake
         assign weak_nxt[p]    = 1'b0;
         assign strong_nxt[p]  = 1'b0;
         assign down_nxt[p]    = 1'b0;
         assign neg_nxt[p]     = 1'b0;
         assign wake_ev_nxt[p] = 1'b0;
      end else begin : g_norm
         logic [PULL_W-1:0] pull;
         logic              neg;
         assign pull = reg_nxt[RI][SB + SLOT_PULL +: PULL_W];
         assign neg  = reg_r[RI][SB + SLOT_WAKE];
         assign weak_nxt[p]   = (pull == PULL_WEAK);
         assign strong_nxt[p] = (pull == PULL_STRONG);
         assign down_nxt[p]   = (pull == PULL_DOWN);
         assign neg_nxt[p]    = reg_nxt[RI][SB + SLOT_WAKE];
         // edge chosen by polarity, held off until the pipe has settled
         assign wake_ev_nxt[p] = (warm_r == WARM_DONE) && !rst_i &&
            (neg ? (wake_prev_r[p] & ~wake_sync_r[p])
                 : (~wake_prev_r[p] & wake_sync_r[p]));
      end
   end

   // settle counter: avoids a false edge from the reset value of the pipe
   always_comb begin
      warm_nxt = warm_r;
      if (warm_r != WARM_DONE) begin
         warm_nxt = warm_r + 2'h1;
      end
      if (rst_i) begin
         warm_nxt = 2'h0;
      end
   end

   // register storage and decoded pad outputs
   always_ff @(posedge clock_i) begin
      reg_r    <= reg_nxt;
      sel_r    <= sel_nxt;
      sin_r    <= reg_nxt[IDX_SCAN_IN][15:0];
      sout_r   <= reg_nxt[IDX_SCAN_OUT][17:0];
      weak_r   <= weak_nxt;
      strong_r <= strong_nxt;
      down_r   <= down_nxt;
      neg_r    <= neg_nxt;
      test_r   <= reg_nxt[IDX_CTL_LOW][TEST_LSB +: TEST_W];
      warm_r   <= warm_nxt;
      wake_ev_r <= wake_ev_nxt;
   end

   // wake pins are asynchronous: two flops before any use
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         wake_meta_r <= '0;
         wake_sync_r <= '0;
         wake_prev_r <= '0;
      end else begin
         wake_meta_r <= wake_pin_i;
         wake_sync_r <= wake_meta_r;
         wake_prev_r <= wake_sync_r;
      end
   end

   // pad side outputs, all straight from flops
   assign pad_func_sel_o    = sel_r;
   assign scan_in_en_o      = sin_r;
   assign scan_out_en_o     = sout_r;
   assign pull_weak_up_o    = weak_r;
   assign pull_strong_up_o  = strong_r;
   assign pull_down_o       = down_r;
   assign wake_negedge_o    = neg_r;
   assign test_config_pin_o = test_r;
   assign wake_event_o      = wake_ev_r;

endmodule : pfs_pad_ctrl

// File: verif/pfs_pad_ctrl_chk.sv
// port checker for the pad control block
`timescale 1ns/100ps
module pfs_pad_ctrl_chk
   import pfs_pkg::*;
(
   input wire logic                         clock_i,
   input wire logic                         rst_i,
   input wire logic                         s_axi_awvalid_i,
   input wire logic                         s_axi_awready_o,
   input wire logic                         s_axi_wvalid_i,
   input wire logic                         s_axi_wready_o,
   input wire logic                         s_axi_bvalid_o,
   input wire logic                         s_axi_arvalid_i,
   input wire logic                         s_axi_arready_o,
   input wire logic                         s_axi_rvalid_o,
   input wire logic [DATA_W-1:0]            s_axi_rdata_o,
   input wire logic [FSEL_PADS*FSEL_W-1:0]  pad_func_sel_o,
   input wire logic [CTL_PINS-1:0]          pull_weak_up_o,
   input wire logic [CTL_PINS-1:0]          pull_strong_up_o,
   input wire logic [CTL_PINS-1:0]          pull_down_o,
   input wire logic [CTL_PINS-1:0]          wake_negedge_o,
   input wire logic [TEST_W-1:0]            test_config_pin_o,
   input wire logic [CTL_PINS-1:0]          wake_pin_i,
   input wire logic [CTL_PINS-1:0]          wake_event_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);

   // reset state shows on the pads at the first edge after release
   rst_cfg_a: assert property ($fell(rst_i) |-> test_config_pin_o == 3'h6)
      else $error("test config wrong after reset");
   rst_pull_a: assert property ($fell(rst_i) |-> pull_down_o == 20'h8
      && (pull_weak_up_o | pull_strong_up_o | wake_negedge_o) == 20'h0)
      else $error("pull or wake wrong after reset");
   rst_sel_a: assert property ($fell(rst_i) |-> pad_func_sel_o == '0)
      else $error("function select not zero after reset");
   // a pad never sees two pull sources at once
   pull_onehot_a: assert property (((pull_weak_up_o & pull_strong_up_o)
      | (pull_weak_up_o & pull_down_o) | (pull_strong_up_o & pull_down_o)) == 20'h0)
      else $error("two pulls on one pad");
   pin8_free_a: assert property (!(pull_weak_up_o[8] | pull_strong_up_o[8]
      | pull_down_o[8] | wake_negedge_o[8] | wake_event_o[8]))
      else $error("test pin slot drives pad controls");
   // wake edge reaches the event output within the sync delay
   wake_rise_a: assert property ($rose(wake_pin_i[0]) && !wake_negedge_o[0]
      |-> ##[2:5] wake_event_o[0])
      else $error("rising wake edge missed");
   wake_fall_a: assert property ($fell(wake_pin_i[1]) && wake_negedge_o[1]
      |-> ##[2:5] wake_event_o[1])
      else $error("falling wake edge missed");
   rd_lat_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read data late");
   rd_resv_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:30] == 2'h0)
      else $error("reserved top bits read non-zero");
   wr_resp_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
      && s_axi_wready_o |-> ##[1:4] s_axi_bvalid_o)
      else $error("write response late");

   wake_c: cover property (wake_event_o[0]);
   write_c: cover property (s_axi_bvalid_o);
   read_c: cover property (s_axi_rvalid_o);
endmodule : pfs_pad_ctrl_chk

// File: verif/pfs_pad_model.sv
// pad model: resolves each pad from its driver and its pulls
`timescale 1ns/100ps
module pfs_pad_model (
   input  wire logic        clock_i,
   input  wire logic [19:0] drive_en_i,
   input  wire logic [19:0] drive_i,
   input  wire logic [19:0] weak_i,
   input  wire logic [19:0] strong_i,
   input  wire logic [19:0] down_i,
   output logic      [19:0] pad_o
);
   logic [19:0] noise_r = 20'h0;
   // a floating pad wanders so no settled guess can pass for a pull
   always_ff @(posedge clock_i) begin
      noise_r <= ~noise_r;
   end
   // driver wins, then pulls, else the wandering level
   assign pad_o = (drive_en_i & drive_i) | (~drive_en_i & (weak_i | strong_i))
                | (~drive_en_i & ~(weak_i | strong_i | down_i) & noise_r);
   // full mux enables sit outside this block; software keeps enable 8 clear
endmodule : pfs_pad_model

// File: verif/pfs_pad_ctrl_tb.sv
// self-checking bench for the pad control block
`timescale 1ns/100ps
module pfs_pad_ctrl_tb
   import pfs_pkg::*;
;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [15:0] awaddr = 16'h0, araddr = 16'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rsp;
   logic [65:0] sel;
   logic [15:0] scin;
   logic [17:0] scout;
   logic [19:0] wup, sup, dn, wneg, wpin, wev, drv = 20'h0;
   logic [2:0]  tcfg;
   logic [15:0] reg_a [7] = '{OFF_SEL_G6, OFF_SEL_G7, OFF_SEL_G8, OFF_SCAN_IN, OFF_SCAN_OUT,
                              OFF_CTL_LOW, OFF_CTL_MID};
   logic [31:0] rst_v [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0600_0C00, 32'h0};
   int          err_total = 0, compares = 0;

   always #12.5 clock_i = ~clock_i;

   pfs_pad_ctrl dut (
      .clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .pad_func_sel_o(sel), .scan_in_en_o(scin), .scan_out_en_o(scout),
      .pull_weak_up_o(wup), .pull_strong_up_o(sup), .pull_down_o(dn),
      .wake_negedge_o(wneg), .test_config_pin_o(tcfg), .wake_pin_i(wpin),
      .wake_event_o(wev));

   // pin 2 left undriven so its pad shows the pull
   pfs_pad_model pads (.clock_i(clock_i), .drive_en_i(20'hFFFFB), .drive_i(drv),
      .weak_i(wup), .strong_i(sup), .down_i(dn), .pad_o(wpin));

   task automatic chk_d(input logic [31:0] g, input logic [31:0] e, input string m);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk_d

   task automatic chk_r(input logic [1:0] g, input logic [1:0] e, input string m);
      chk_d({30'h0, g}, {30'h0, e}, m);
   endtask : chk_r

   // bus write; address and data released as each is taken
   task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (aw_p || w_p) begin
         @(posedge clock_i);
         if (aw_p && awready === 1'b1) begin
            aw_p = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_p && wready === 1'b1) begin
            w_p = 1'b0;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clock_i); while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
      @(posedge clock_i);
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [31:0] v);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock_i); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clock_i); while (rvalid !== 1'b1);
      v = rdata;
      rsp = rresp;
      rready <= 1'b0;
      @(posedge clock_i);
   endtask : rd

   // accumulate wake pulses over the sync delay after a pin change
   task automatic wake(input logic [19:0] lvl, input logic [19:0] e);
      logic [19:0] acc;
      acc = 20'h0;
      drv <= lvl;
      repeat (8) begin
         @(posedge clock_i);
         acc = acc | wev;
      end
      chk_d({12'h0, acc & 20'hFFFFB}, {12'h0, e}, "wake events");
   endtask : wake

   task automatic rst_chk();
      @(posedge clock_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      chk_d({29'h0, tcfg}, 32'h6, "test cfg");
      chk_d({12'h0, dn}, 32'h8, "pull down");
      chk_d({12'h0, wup | sup | wneg}, 32'h0, "pull up");
      chk_d({31'h0, |sel}, 32'h0, "select");
      for (int i = 0; i < 7; i++) begin
         rd(reg_a[i], d);
         chk_d(d, rst_v[i], "reset value");
      end
   endtask : rst_chk

   task automatic results();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   initial begin
      rst_chk();
      $display("test reset done");
      // selects: reserved gaps drop, each pad lands in its own field
      for (int i = 0; i < 3; i++) begin
         wr(reg_a[i], 32'hFFFF_FFFF, 4'hF);
         rd(reg_a[i], d);
         chk_d(d, (i == 2) ? 32'h003F_3F3F : 32'h3F3F_3F3F, "sel mask");
         d = {2'h0, 6'(4*i+4), 2'h0, 6'(4*i+3), 2'h0, 6'(4*i+2), 2'h0, 6'(4*i+1)};
         wr(reg_a[i], d, 4'hF);
      end
      for (int k = 0; k < 11; k++) chk_d({26'h0, sel[6*k +: 6]}, 32'(k + 1), "pad sel");
      wr(OFF_SEL_G6, 32'h0000_3F00, 4'h2);
      rd(OFF_SEL_G6, d);
      chk_d(d, 32'h0403_3F01, "strobe");
      $display("test select done");
      wr(OFF_SCAN_IN, 32'hFFFF_FFFF, 4'hF);
      wr(OFF_SCAN_OUT, 32'hFFFF_FFFF, 4'hF);
      chk_d({scout[17:2], scin}, 32'hFFFF_FFFF, "scan enables");
      chk_d({30'h0, scout[1:0]}, 32'h3, "scan out low");
      wr(16'h003C, 32'hFFFF_FFFF, 4'hF);
      chk_r(rsp, RESP_SLVERR, "unmapped write");
      rd(16'h003C, d);
      chk_d(d, 32'h0, "unmapped read");
      chk_r(rsp, RESP_SLVERR, "unmapped read resp");
      $display("test scan done");
      // every pull code on pin 2
      for (int c = 0; c < 4; c++) begin
         wr(OFF_CTL_LOW, 32'(c) << 7, 4'hF);
         chk_d({28'h0, wup[2], sup[2], dn[2], wpin[2] & (c != 0)},
               {28'h0, c == 1, c == 2, c == 3, c == 1 || c == 2}, "pull code");
      end
      wr(OFF_CTL_LOW, 32'hFFFF_FFFF, 4'hF);
      rd(OFF_CTL_LOW, d);
      chk_d(d, 32'h3FFF_FFFF, "low word");
      chk_d({12'h0, dn & wneg}, 32'h2FF, "pin 8 slot");
      chk_d({29'h0, tcfg}, 32'h7, "test cfg");
      wr(OFF_CTL_LOW, 32'h3800_0000, 4'hF);
      chk_d({12'h0, dn | wup | sup}, 32'h200, "pin 9 pull");
      wr(OFF_CTL_MID, 32'h1C00_0000, 4'hF);
      chk_d({2'h0, wup[19:10], sup[19:10], wneg[19:10]}, {2'h0, 10'h200, 10'h100, 10'h200},
            "mid word");
      $display("test pull done");
      // pin 0 wakes on rise, pin 1 on fall; pin 2 held up
      wr(OFF_CTL_LOW, 32'h0000_0088, 4'hF);
      wake(20'h3, 20'h1);
      wake(20'h0, 20'h2);
      rd(OFF_WAKE_LVL, d);
      chk_d(d, 32'h4, "wake level");
      $display("test wake done");
      rst_chk();
      $display("test second reset done");
      results();
   end

   // watchdog well past the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clock_i);
      err_total++;
      $display("mismatch at %0t: watchdog expired", $time);
      results();
   end
endmodule : pfs_pad_ctrl_tb

bind pfs_pad_ctrl pfs_pad_ctrl_chk chk (.clock_i(clock_i), .rst_i(rst_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rdata_o(s_axi_rdata_o), .pad_func_sel_o(pad_func_sel_o),
   .pull_weak_up_o(pull_weak_up_o), .pull_strong_up_o(pull_strong_up_o),
   .pull_down_o(pull_down_o), .wake_negedge_o(wake_negedge_o),
   .test_config_pin_o(test_config_pin_o), .wake_pin_i(wake_pin_i),
   .wake_event_o(wake_event_o));
